// [hw/sbsr_pkg.sv]
// package for the status byte and service request block
// assumes one system clock; no bus, registers reached through command strobes
package sbsr_pkg;
	// ==========================================
	// bit positions of the status byte
	localparam int SBSR_BIT_TIMEOUT = 0;
	localparam int SBSR_BIT_BUS_ERR = 1;
	localparam int SBSR_BIT_OMA = 4;
	localparam int SBSR_BIT_EVENT_SUM = 5;
	localparam int SBSR_BIT_SUMMARY = 6;
	localparam logic [7:0] SBSR_MASK_RESET = 8'h00;
	localparam logic [7:0] SBSR_BYTE_ZERO = 8'h00;
	// ==========================================
	// query answer kinds
	typedef enum logic [1:0] {
		SBSR_ANS_NONE,
		SBSR_ANS_STATUS,
		SBSR_ANS_POLL,
		SBSR_ANS_MASK
	} sbsr_ans_t;
	// ==========================================
	// command group from the parser
	typedef struct packed {
		logic mask_write;
		logic [7:0] mask_data;
		logic status_query;
		logic mask_query;
		logic serial_poll;
	} sbsr_cmd_t;
	// answer group back to the parser
	typedef struct packed {
		logic valid;
		sbsr_ans_t kind;
		logic [7:0] data;
	} sbsr_resp_t;
	// whole state of the block
	typedef struct packed {
		logic [7:0] request_enable_mask;
		logic master_summary;
		logic request_service_flag;
		logic srq;
		sbsr_resp_t resp;
	} sbsr_state_t;
endpackage : sbsr_pkg

// [hw/sbsr_top.sv]
// status byte, enable mask, summary and service request of the remote interface
// assumes event inputs and command strobes synchronous to clock_in
`timescale 1ns/10ps
module sbsr_top (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [7:0] std_event_in,
	input wire logic [7:0] std_event_enable_in,
	input wire logic queue_not_empty_in,
	input wire logic local_bus_error_flag_in,
	input wire logic local_bus_timeout_flag_in,
	input wire logic gpib_selected_in,
	input wire sbsr_pkg::sbsr_cmd_t cmd_in,
	output sbsr_pkg::sbsr_resp_t resp_out,
	output logic master_summary_out,
	output logic srq_out
);
	import sbsr_pkg::*;

	sbsr_state_t state_reg;
	sbsr_state_t state_next;
	logic [7:0] status_summary_byte;
	logic summary_now;

	// ==========================================
	// status byte assembly; unused positions stay zero
	always_comb begin
		status_summary_byte = SBSR_BYTE_ZERO;
		status_summary_byte[SBSR_BIT_EVENT_SUM] =
			|(std_event_in & std_event_enable_in);
		status_summary_byte[SBSR_BIT_OMA] = queue_not_empty_in;
		status_summary_byte[SBSR_BIT_BUS_ERR] = local_bus_error_flag_in;
		status_summary_byte[SBSR_BIT_TIMEOUT] = local_bus_timeout_flag_in;
		// bit six is never a source, so it cannot feed back into itself
		summary_now = |(status_summary_byte & state_reg.request_enable_mask);
	end

	// ==========================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.resp.valid = 1'b0;
		state_next.resp.kind = SBSR_ANS_NONE;
		state_next.resp.data = SBSR_BYTE_ZERO;
		if (cmd_in.mask_write) begin
			state_next.request_enable_mask = cmd_in.mask_data;
		end
		state_next.master_summary = summary_now;
		// a poll clears the flag, but a fresh rising edge in that cycle wins
		if (!summary_now) begin
			state_next.request_service_flag = 1'b0;
		end else if (!state_reg.master_summary) begin
			state_next.request_service_flag = 1'b1;
		end else if (cmd_in.serial_poll) begin
			state_next.request_service_flag = 1'b0;
		end
		state_next.srq = state_next.request_service_flag & gpib_selected_in;
		// answers are binary; decimal text is the parser's job
		if (cmd_in.serial_poll) begin
			state_next.resp.valid = 1'b1;
			state_next.resp.kind = SBSR_ANS_POLL;
			state_next.resp.data = status_summary_byte;
			state_next.resp.data[SBSR_BIT_SUMMARY] = state_reg.request_service_flag;
		end else if (cmd_in.status_query) begin
			state_next.resp.valid = 1'b1;
			state_next.resp.kind = SBSR_ANS_STATUS;
			state_next.resp.data = status_summary_byte;
			state_next.resp.data[SBSR_BIT_SUMMARY] = summary_now;
		end else if (cmd_in.mask_query) begin
			state_next.resp.valid = 1'b1;
			state_next.resp.kind = SBSR_ANS_MASK;
			state_next.resp.data = state_reg.request_enable_mask;
		end
		if (!rst_b_in) begin
			state_next = '0;
			state_next.request_enable_mask = SBSR_MASK_RESET;
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clock_in) begin
		state_reg <= state_next;
	end

	assign resp_out = state_reg.resp;
	assign master_summary_out = state_reg.master_summary;
	assign srq_out = state_reg.srq;

	// ==========================================
	// checks
	// the summary is the OR of the masked bits seen one edge earlier
	a_summary_follows: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		$past(rst_b_in) |-> master_summary_out == |($past(status_summary_byte)
		& $past(state_reg.request_enable_mask))
	) else $error("summary wrong");

	// an all-zero mask hides every status bit from the summary
	a_mask_gates: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		state_reg.request_enable_mask == SBSR_BYTE_ZERO |=> !master_summary_out
	) else $error("summary with empty mask");

	// a rising summary must leave the request flag set
	a_flag_rises: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		$rose(master_summary_out) |-> state_reg.request_service_flag
	) else $error("request flag not set");

	// a rising summary beats a poll arriving in the same cycle
	a_flag_set_wins: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		summary_now && !state_reg.master_summary |=> state_reg.request_service_flag
	) else $error("rising summary lost");

	// no request flag survives a summary at zero
	a_flag_falls: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		!master_summary_out |-> !state_reg.request_service_flag
	) else $error("request flag not cleared");

	// a poll on a steady summary clears the flag at the next edge
	a_poll_clears: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		cmd_in.serial_poll && state_reg.master_summary && summary_now
		|=> !state_reg.request_service_flag
	) else $error("poll did not clear flag");

	// event summary in answers comes from enabled standard events
	a_event_bit: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind != SBSR_ANS_MASK
		|-> resp_out.data[SBSR_BIT_EVENT_SUM]
		== |($past(std_event_in) & $past(std_event_enable_in))
	) else $error("event summary bit wrong");

	// message bit in answers follows the queue one edge earlier
	a_message_bit: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind != SBSR_ANS_MASK
		|-> resp_out.data[SBSR_BIT_OMA] == $past(queue_not_empty_in)
	) else $error("message bit wrong");

	// local bus flags sit at bits one and zero
	a_error_bits: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind != SBSR_ANS_MASK
		|-> resp_out.data[SBSR_BIT_BUS_ERR] == $past(local_bus_error_flag_in)
		&& resp_out.data[SBSR_BIT_TIMEOUT] == $past(local_bus_timeout_flag_in)
	) else $error("local bus bits wrong");

	// unused positions of a status or poll answer stay zero
	a_unused_zero: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind != SBSR_ANS_MASK |-> resp_out.data[7] == 1'b0
		&& resp_out.data[3:2] == 2'b00
	) else $error("unused bit set");

	// a write lands in the mask at the taking edge
	a_mask_write: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		cmd_in.mask_write |=> state_reg.request_enable_mask == $past(cmd_in.mask_data)
	) else $error("mask write lost");

	// a mask query right after a write echoes the written byte
	a_mask_echo: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		cmd_in.mask_write ##1 (cmd_in.mask_query && !cmd_in.mask_write
		&& !cmd_in.status_query && !cmd_in.serial_poll)
		|=> resp_out.data == $past(cmd_in.mask_data, 2)
	) else $error("mask echo");

	// every reset cycle leaves the mask at its reset value
	a_mask_reset: assert property (
		@(posedge clock_in)
		!rst_b_in |=> state_reg.request_enable_mask == SBSR_MASK_RESET
	) else $error("mask not cleared");

	// without a write the mask holds its value
	a_mask_hold: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		!cmd_in.mask_write |=> $stable(state_reg.request_enable_mask)
	) else $error("mask changed without write");

	// a status answer carries the summary taken at the same edge
	a_status_summary: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind == SBSR_ANS_STATUS
		|-> resp_out.data[SBSR_BIT_SUMMARY] == master_summary_out
	) else $error("status summary bit wrong");

	// a status query on a steady summary leaves the mask and the request flag unchanged
	a_query_nonclear: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		cmd_in.status_query && !cmd_in.serial_poll && !cmd_in.mask_write
		&& summary_now == state_reg.master_summary
		|=> $stable(state_reg.request_enable_mask)
		&& $stable(state_reg.request_service_flag)
	) else $error("query changed state");

	// a poll answer carries the flag as it stood before the poll
	a_poll_flag: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		resp_out.valid && resp_out.kind == SBSR_ANS_POLL
		|-> resp_out.data[SBSR_BIT_SUMMARY] == $past(state_reg.request_service_flag)
	) else $error("poll flag bit wrong");

	// no service request while another interface is selected
	a_srq_gpib: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		!gpib_selected_in |=> !srq_out
	) else $error("srq off the gpib port");

	// the service request never stands without the flag
	a_srq_follows: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		srq_out |-> state_reg.request_service_flag
	) else $error("srq without flag");

	// a set flag with the gpib port selected drives the request
	a_srq_set: assert property (
		@(posedge clock_in) disable iff (!rst_b_in)
		state_reg.request_service_flag && $past(gpib_selected_in) |-> srq_out
	) else $error("flag without srq");
endmodule : sbsr_top

// [testbench/sbsr_ctrl_model.sv]
// remote controller model: turns a bench op code into one command strobe
// assumes the bench changes op_in at falling edges, one command per cycle
`timescale 1ns/10ps
module sbsr_ctrl_model (
	input wire logic [2:0] op_in,
	input wire logic [7:0] data_in,
	output sbsr_pkg::sbsr_cmd_t cmd_out
);
	import sbsr_pkg::*;
	// ==========================================
	// op 1 write, 2 status query, 3 mask query, 4 poll; a byte port keeps 0..255
	always_comb begin
		cmd_out = '0;
		cmd_out.mask_write = (op_in == 3'h1);
		cmd_out.mask_data = data_in;
		cmd_out.status_query = (op_in == 3'h2);
		cmd_out.mask_query = (op_in == 3'h3);
		cmd_out.serial_poll = (op_in == 3'h4);
	end
endmodule : sbsr_ctrl_model

// [testbench/sbsr_top_bench.sv]
// self-checking bench for the status byte and service request block
// assumes inputs change at the falling edge, answers registered at the taking edge
`timescale 1ns/10ps
module sbsr_top_bench;
	import sbsr_pkg::*;
	logic clock_in = 0, rst_b_in = 0, q = 0, er = 0, tout = 0, gp = 1, summ, srq;
	logic [2:0] op = 3'h0;
	logic [7:0] d = 8'h00, ev = 8'h00, een = 8'h20;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	sbsr_cmd_t cmd;
	sbsr_resp_t resp;
	// ==========================================
	// clock, partner and design
	always #2 clock_in = ~clock_in;
	sbsr_ctrl_model sbsr_ctrl_model_inst (.op_in(op), .data_in(d), .cmd_out(cmd));
	sbsr_top sbsr_top_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .std_event_in(ev),
		.std_event_enable_in(een), .queue_not_empty_in(q), .local_bus_error_flag_in(er),
		.local_bus_timeout_flag_in(tout), .gpib_selected_in(gp), .cmd_in(cmd),
		.resp_out(resp), .master_summary_out(summ), .srq_out(srq));
	// a hang is cut short well past the few dozen cycles the tests need
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// one command, judged at the falling edge after the taking edge; op is left standing so that
	// back-to-back commands need no idle cycle, and the caller drops it when done
	task automatic req(input logic [2:0] o, input logic [7:0] v, input sbsr_ans_t k,
		input logic [7:0] e);
		op = o;
		d = v;
		@(negedge clock_in);
		if (o != 3'h1) chk({resp.valid, 5'h00, resp.kind}, {1'b1, 5'h00, k});
		if (o != 3'h1) chk(resp.data, e);
	endtask : req
	// levels are registered, so give them two falling edges to settle
	task automatic settle();
		repeat (2) @(negedge clock_in);
	endtask : settle
	// ==========================================
	// scenarios
	task automatic t_mask();
		req(3'h3, 8'h00, SBSR_ANS_MASK, 8'h00);
		req(3'h1, 8'hff, SBSR_ANS_NONE, 8'h00);
		req(3'h3, 8'h00, SBSR_ANS_MASK, 8'hff);
		// a reset in mid-run must drop the stored mask
		op = 3'h0;
		rst_b_in = 0;
		repeat (2) @(negedge clock_in);
		rst_b_in = 1;
		req(3'h3, 8'h00, SBSR_ANS_MASK, 8'h00);
		req(3'h1, 8'h30, SBSR_ANS_NONE, 8'h00);
		op = 3'h0;
		$display("t_mask done");
	endtask : t_mask
	task automatic t_poll();
		q = 1;
		settle();
		chk({6'h00, summ, srq}, 8'h03);
		req(3'h2, 8'h00, SBSR_ANS_STATUS, 8'h50);
		req(3'h2, 8'h00, SBSR_ANS_STATUS, 8'h50);
		req(3'h4, 8'h00, SBSR_ANS_POLL, 8'h50);
		chk({7'h00, srq}, 8'h00);
		req(3'h4, 8'h00, SBSR_ANS_POLL, 8'h10);
		op = 3'h0;
		q = 0;
		settle();
		chk({7'h00, summ}, 8'h00);
		$display("t_poll done");
	endtask : t_poll
	task automatic t_masked();
		er = 1;
		tout = 1;
		gp = 0;
		settle();
		req(3'h2, 8'h00, SBSR_ANS_STATUS, 8'h03);
		op = 3'h0;
		ev = 8'h20;
		settle();
		chk({6'h00, summ, srq}, 8'h02);
		req(3'h2, 8'h00, SBSR_ANS_STATUS, 8'h63);
		op = 3'h0;
		// an event outside the event enable must not reach the summary
		ev = 8'h10;
		settle();
		req(3'h2, 8'h00, SBSR_ANS_STATUS, 8'h03);
		req(3'h4, 8'h00, SBSR_ANS_POLL, 8'h03);
		op = 3'h0;
		$display("t_masked done");
	endtask : t_masked
	initial begin
		repeat (8) @(negedge clock_in);
		rst_b_in = 1;
		t_mask();
		t_poll();
		t_masked();
		final_report();
	end
endmodule : sbsr_top_bench
